// >>> hw/sbtc_edge_sync.v
// Two-flop synchroniser with rise and fall detection on the second stage.
`timescale 1ns/1ps
`default_nettype none
module sbtc_edge_sync (
  // Clock and reset.
  input  wire core_clk,
  input  wire nrst,
  // Asynchronous level in, synchronous edge pulses out.
  input  wire asyncIn,
  output wire levelOut,
  output wire riseOut,
  output wire fallOut
);
  reg meta_ff;
  reg sync_ff;
  reg prev_ff;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign levelOut = sync_ff;
  assign riseOut  = sync_ff & ~prev_ff;
  assign fallOut  = ~sync_ff & prev_ff;
endmodule // sbtc_edge_sync
`default_nettype wire

// >>> hw/sbtc_timer.v
// Sixteen-bit timer/counter with APB register access and a masked interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "sbtc_map.vh"
module sbtc_timer #(
  parameter INSTR_DIV = `SBTC_INSTR_DIV
) (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        nrst,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Oscillator pins, input side and port driver.
  input  wire        oscOutClockInPin,
  input  wire        oscInPin,
  output reg  [1:0]  pinOut,
  output reg  [1:0]  pinOe,
  // System context.
  input  wire        compareTrigger,
  input  wire        sleepMode,
  input  wire        clockMonitorEn,
  input  wire        timerOscFailed,
  // Interrupts.
  output reg         overflowIrq,
  output reg         irq
);
  reg [7:0]  countLow_ff;
  reg [7:0]  countHigh_ff;
  reg [6:0]  ctrl_ff;
  reg        ovfFlag_ff;
  reg        ovfEn_ff;
  reg [1:0]  status_ff;
  reg [1:0]  mask_ff;
  reg [1:0]  sysClkSel_ff;
  reg [1:0]  portDir_ff;
  reg [1:0]  portData_ff;
  reg [1:0]  instrDiv_ff;
  reg [2:0]  prescale_ff;
  reg        armed_ff;
  reg        prevOn_ff;
  reg        prevCs_ff;
  reg [31:0] nxt_prdata;
  reg        nxt_slverr;
  reg        runBit;
  reg        tick;
  reg        scaledTick;
  reg [2:0]  nxt_prescale;
  reg        extTick;
  reg [7:0]  nxt_countLow;
  reg [7:0]  nxt_countHigh;
  reg        nxt_ovfFlag;
  reg [1:0]  nxt_status;
  reg        nxt_overflowIrq;
  reg        nxt_irq;

  localparam [7:0] CTRL_RST = `SBTC_CTRL_RST;

  wire       timerOn  = ctrl_ff[`SBTC_BIT_ON];
  wire       clkSel   = ctrl_ff[`SBTC_BIT_CS];
  wire       syncN    = ctrl_ff[`SBTC_BIT_SYNCN];
  wire       oscEn    = ctrl_ff[`SBTC_BIT_OSCEN];
  wire [1:0] psSel    = ctrl_ff[`SBTC_BIT_PS_HI:`SBTC_BIT_PS_LO];
  wire       extSel   = oscEn ? oscInPin : oscOutClockInPin;
  wire       extRise;
  wire       extFall;
  wire       access   = psel & penable & ~pready;
  // Writes and clear-on-read act on the edge that samples pready high.
  wire       done     = psel & penable & pready;
  wire       wrEn     = done & pwrite;
  wire       rdEn     = done & ~pwrite;
  wire [15:0] countPair = {countHigh_ff, countLow_ff};
  wire       wrap;
  wire       irqNext;

  // Address decode of the register map.
  wire       hitLow    = (paddr == `SBTC_OFF_LOW);
  wire       hitHigh   = (paddr == `SBTC_OFF_HIGH);
  wire       hitCtrl   = (paddr == `SBTC_OFF_CTRL);
  wire       hitFlag   = (paddr == `SBTC_OFF_FLAG);
  wire       hitEnable = (paddr == `SBTC_OFF_ENABLE);
  wire       hitStatus = (paddr == `SBTC_OFF_STATUS);
  wire       hitMask   = (paddr == `SBTC_OFF_MASK);
  wire       hitSysClk = (paddr == `SBTC_OFF_SYSCLK);
  wire       hitPort   = (paddr == `SBTC_OFF_PORT);
  wire       wrLow     = wrEn & hitLow;
  wire       wrHigh    = wrEn & hitHigh;
  wire       wrFlagClr = wrEn & hitFlag & ~pwdata[`SBTC_BIT_OVF];
  wire       rdStatus  = rdEn & hitStatus;

  sbtc_edge_sync extSync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .asyncIn  (extSel),
    .levelOut (),
    .riseOut  (extRise),
    .fallOut  (extFall)
  );

  // Decide where a count step comes from and apply the prescaler.
  always @* begin
    extTick      = armed_ff & extRise;
    tick         = 1'b0;
    nxt_prescale = prescale_ff;
    scaledTick   = 1'b0;
    if (timerOn) begin
      if (!clkSel) begin
        tick = (instrDiv_ff == INSTR_DIV - 1);
      end else begin
        tick = extTick;
      end
    end
    if (tick) begin
      nxt_prescale = prescale_ff + 3'd1;
      case (psSel)
        2'd0:    scaledTick = 1'b1;
        2'd1:    scaledTick = prescale_ff[0];
        2'd2:    scaledTick = &prescale_ff[1:0];
        default: scaledTick = &prescale_ff;
      endcase
      if (scaledTick) begin
        nxt_prescale = 3'd0;
      end
    end
  end

  // In synchronized counter mode sleep halts the count, not the prescaler.
  wire step = scaledTick & ~(clkSel & ~syncN & sleepMode);
  assign wrap    = step & (countPair == 16'hffff);
  assign irqNext = |(status_ff & mask_ff);

  // Run status: oscillator selected and, under the monitor, still alive.
  always @* begin
    runBit = (sysClkSel_ff == `SBTC_SCS_TMROSC) & oscEn;
    if (clockMonitorEn & timerOscFailed) begin
      runBit = 1'b0;
    end
  end

  // Instruction-cycle divider and prescaler.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      instrDiv_ff <= 2'd0;
      prescale_ff <= 3'd0;
    end else begin
      instrDiv_ff <= (instrDiv_ff == INSTR_DIV - 1) ? 2'd0 : instrDiv_ff + 2'd1;
      prescale_ff <= nxt_prescale;
    end
  end

  // Counting edges are armed only by a falling edge seen after enabling.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armed_ff  <= 1'b0;
      prevOn_ff <= 1'b0;
      prevCs_ff <= 1'b0;
    end else begin
      prevOn_ff <= timerOn;
      prevCs_ff <= clkSel;
      if ((timerOn & ~prevOn_ff) | (clkSel & ~prevCs_ff) | ~timerOn) begin
        armed_ff <= 1'b0;
      end else if (extFall) begin
        armed_ff <= 1'b1;
      end
    end
  end

  // Next count: the compare trigger beats a software write, which beats a step.
  always @* begin
    nxt_countLow  = countLow_ff;
    nxt_countHigh = countHigh_ff;
    if (compareTrigger) begin
      nxt_countLow  = 8'h00;
      nxt_countHigh = 8'h00;
    end else if (wrLow) begin
      nxt_countLow = pwdata[7:0];
    end else if (wrHigh) begin
      nxt_countHigh = pwdata[7:0];
    end else if (step) begin
      nxt_countLow = countLow_ff + 8'h01;
      if (countLow_ff == 8'hff) begin
        nxt_countHigh = countHigh_ff + 8'h01;
      end
    end
  end

  // Next flags: a hardware event in the cycle of its clear keeps the bit set.
  always @* begin
    nxt_ovfFlag = ovfFlag_ff;
    if (wrFlagClr) begin
      nxt_ovfFlag = 1'b0;
    end
    if (wrap) begin
      nxt_ovfFlag = 1'b1;
    end
    nxt_status = status_ff;
    if (rdStatus) begin
      nxt_status = 2'b00;
    end
    nxt_status      = nxt_status | {compareTrigger, wrap};
    nxt_overflowIrq = (ovfFlag_ff | wrap) & ovfEn_ff;
    nxt_irq         = irqNext;
  end

  // Count pair.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      countLow_ff  <= 8'h00;
      countHigh_ff <= 8'h00;
    end else begin
      countLow_ff  <= nxt_countLow;
      countHigh_ff <= nxt_countHigh;
    end
  end

  // Software-owned control registers.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff      <= CTRL_RST[6:0];
      ovfEn_ff     <= 1'b0;
      mask_ff      <= 2'b00;
      sysClkSel_ff <= 2'b00;
      portDir_ff   <= 2'b11;
      portData_ff  <= 2'b00;
    end else begin
      if (wrEn & hitCtrl) begin
        ctrl_ff <= {1'b0, pwdata[5:0]};
      end
      if (wrEn & hitEnable) begin
        ovfEn_ff <= pwdata[`SBTC_BIT_OVF];
      end
      if (wrEn & hitMask) begin
        mask_ff <= pwdata[1:0];
      end
      if (wrEn & hitSysClk) begin
        sysClkSel_ff <= pwdata[1:0];
      end
      if (wrEn & hitPort) begin
        portDir_ff  <= pwdata[1:0];
        portData_ff <= pwdata[9:8];
      end
    end
  end

  // Flags and interrupt outputs.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ovfFlag_ff  <= 1'b0;
      status_ff   <= 2'b00;
      overflowIrq <= 1'b0;
      irq         <= 1'b0;
    end else begin
      ovfFlag_ff  <= nxt_ovfFlag;
      status_ff   <= nxt_status;
      overflowIrq <= nxt_overflowIrq;
      irq         <= nxt_irq;
    end
  end

  // Pin drivers: an enabled oscillator takes both pins as inputs.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinOut <= 2'b00;
      pinOe  <= 2'b00;
    end else begin
      pinOut <= portData_ff;
      pinOe  <= oscEn ? 2'b00 : ~portDir_ff;
    end
  end

  // Read mux and APB answer, one wait state.
  always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    case (paddr)
      `SBTC_OFF_LOW:    nxt_prdata[7:0] = countLow_ff;
      `SBTC_OFF_HIGH:   nxt_prdata[7:0] = countHigh_ff;
      `SBTC_OFF_CTRL:   nxt_prdata[6:0] = {runBit, ctrl_ff[5:0]};
      `SBTC_OFF_FLAG:   nxt_prdata[0]   = ovfFlag_ff;
      `SBTC_OFF_ENABLE: nxt_prdata[0]   = ovfEn_ff;
      `SBTC_OFF_STATUS: nxt_prdata[1:0] = status_ff;
      `SBTC_OFF_MASK:   nxt_prdata[1:0] = mask_ff;
      `SBTC_OFF_SYSCLK: nxt_prdata[1:0] = sysClkSel_ff;
      `SBTC_OFF_PORT:   begin
        nxt_prdata[1:0] = portDir_ff;
        nxt_prdata[9:8] = portData_ff;
        nxt_prdata[17:16] = oscEn ? 2'b00 : {oscInPin, oscOutClockInPin};
      end
      default:          nxt_slverr = 1'b1;
    endcase
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access & nxt_slverr;
      if (access && !pwrite) begin
        prdata <= nxt_prdata;
      end
    end
  end
endmodule // sbtc_timer
`default_nettype wire

// >>> shared/sbtc_map.vh
// Register map, field positions, reset values and timing for the 16-bit timer/counter.
`ifndef SBTC_MAP_VH
`define SBTC_MAP_VH
`define SBTC_OFF_LOW      12'h000
`define SBTC_OFF_HIGH     12'h004
`define SBTC_OFF_CTRL     12'h008
`define SBTC_OFF_FLAG     12'h00c
`define SBTC_OFF_ENABLE   12'h010
`define SBTC_OFF_STATUS   12'h014
`define SBTC_OFF_MASK     12'h018
`define SBTC_OFF_SYSCLK   12'h01c
`define SBTC_OFF_PORT     12'h020
`define SBTC_BIT_ON       0
`define SBTC_BIT_CS       1
`define SBTC_BIT_SYNCN    2
`define SBTC_BIT_OSCEN    3
`define SBTC_BIT_PS_LO    4
`define SBTC_BIT_PS_HI    5
`define SBTC_BIT_RUN      6
`define SBTC_BIT_OVF      0
`define SBTC_EV_OVF       0
`define SBTC_EV_TRIG      1
`define SBTC_SCS_TMROSC   2'b01
`define SBTC_CTRL_RST     8'h00
`define SBTC_INSTR_DIV    4
`endif

// >>> verification/sbtc_ext_clock.sv
// Model of the external clock source that feeds the two oscillator pins.
`timescale 1ns/1ps
`default_nettype none
module sbtc_ext_clock (
  // Pins toward the timer.
  output logic clkInPin,
  output logic oscPin
);
  initial {clkInPin, oscPin} = 2'b00;
  // Both pins rest low between bursts; the odd period keeps pin edges off clock edges.
  task automatic pulses(input bit onOsc, input int n);
    repeat (n) begin
      #97 if (onOsc) oscPin = 1'b1; else clkInPin = 1'b1;
      #100 {clkInPin, oscPin} = 2'b00;
    end
  endtask
endmodule // sbtc_ext_clock
`default_nettype wire

// >>> verification/sbtc_timer_bench.sv
// Self-checking bench for the timer/counter over APB with an external clock model.
`timescale 1ns/1ps
`default_nettype none
`include "sbtc_map.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module sbtc_timer_bench;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, overflowIrq, irq, er;
  logic [1:0]  pinOut, pinOe;
  logic        compareTrigger = 1'b0, sleepMode = 1'b0;
  logic        clockMonitorEn = 1'b0, timerOscFailed = 1'b0;
  wire         clkInPin, oscPin;
  int          err_count = 0, cmp_count = 0;
  always #10 core_clk = ~core_clk;
  sbtc_timer #(.INSTR_DIV(4)) DUT (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oscOutClockInPin(clkInPin), .oscInPin(oscPin),
    .pinOut(pinOut), .pinOe(pinOe), .compareTrigger(compareTrigger), .sleepMode(sleepMode),
    .clockMonitorEn(clockMonitorEn), .timerOscFailed(timerOscFailed),
    .overflowIrq(overflowIrq), .irq(irq));
  sbtc_ext_clock ext (.clkInPin(clkInPin), .oscPin(oscPin));
  task automatic xfer(input [11:0] a, input w, input [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    do begin @(posedge core_clk); n++; end while (!pready && n < 50);
    `CHK("pready", 1'b1, pready)
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input [11:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic chkRd(input [11:0] a, input [31:0] ex);
    xfer(a, 1'b0, 32'h0);
    `CHK($sformatf("reg %h", a), ex, rd)
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chkRd(`SBTC_OFF_CTRL, {24'h0, `SBTC_CTRL_RST});
    xfer(12'h040, 1'b0, 32'h0);
    `CHK("pslverr", 1'b1, er)
    wr(`SBTC_OFF_LOW, 32'hff);
    wr(`SBTC_OFF_HIGH, 32'hff);
    wr(`SBTC_OFF_CTRL, 32'h1);
    repeat (20) @(posedge core_clk);
    wr(`SBTC_OFF_CTRL, 32'h0);
    chkRd(`SBTC_OFF_HIGH, 32'h0);
    `CHK("overflowIrq", 1'b0, overflowIrq)
    chkRd(`SBTC_OFF_FLAG, 32'h1);
    wr(`SBTC_OFF_ENABLE, 32'h1);
    @(posedge core_clk);
    `CHK("overflowIrq", 1'b1, overflowIrq)
    `CHK("irq", 1'b0, irq)
    wr(`SBTC_OFF_MASK, 32'h1);
    @(posedge core_clk);
    `CHK("irq", 1'b1, irq)
    chkRd(`SBTC_OFF_STATUS, 32'h1);
    @(posedge core_clk);
    `CHK("irq", 1'b0, irq)
    wr(`SBTC_OFF_FLAG, 32'h1);
    chkRd(`SBTC_OFF_FLAG, 32'h1);
    wr(`SBTC_OFF_FLAG, 32'h0);
    @(posedge core_clk);
    `CHK("overflowIrq", 1'b0, overflowIrq)
    // Timer mode with the sync bit set: it must be ignored, one count per four clocks.
    wr(`SBTC_OFF_LOW, 32'h0);
    wr(`SBTC_OFF_CTRL, 32'h5);
    repeat (400) @(posedge core_clk);
    wr(`SBTC_OFF_CTRL, 32'h0);
    xfer(`SBTC_OFF_LOW, 1'b0, 32'h0);
    `CHK("timer rate", 1'b1, rd >= 100 && rd <= 102)
    wr(`SBTC_OFF_LOW, 32'h42);
    repeat (50) @(posedge core_clk);
    chkRd(`SBTC_OFF_LOW, 32'h42);
    compareTrigger <= 1'b1;
    @(posedge core_clk) compareTrigger <= 1'b0;
    chkRd(`SBTC_OFF_LOW, 32'h0);
    chkRd(`SBTC_OFF_STATUS, 32'h2);
    // Pin starts low, so the first rise after enabling is lost; with sleep set (j == 2) no rise counts.
    for (int j = 0; j < 4; j++) begin
      sleepMode <= (j == 2);
      wr(`SBTC_OFF_CTRL, 32'h0);
      wr(`SBTC_OFF_LOW, 32'h0);
      wr(`SBTC_OFF_CTRL, (j == 3) ? 32'hb : 32'h3 | ((j == 1) << 2));
      ext.pulses(1'b0, 5);
      ext.pulses(j == 3, 5);
      repeat (5) @(posedge core_clk);
      chkRd(`SBTC_OFF_LOW, (j == 2) ? 32'h0 : (j == 3) ? 32'h4 : 32'h9);
    end
    sleepMode <= 1'b0;
    wr(`SBTC_OFF_CTRL, 32'h0);
    wr(`SBTC_OFF_PORT, 32'h300);
    @(posedge core_clk);
    `CHK("pinOe", 2'b11, pinOe)
    `CHK("pinOut", 2'b11, pinOut)
    wr(`SBTC_OFF_SYSCLK, 32'h1);
    wr(`SBTC_OFF_CTRL, 32'h8);
    @(posedge core_clk);
    `CHK("pinOe", 2'b00, pinOe)
    chkRd(`SBTC_OFF_PORT, 32'h300);
    chkRd(`SBTC_OFF_CTRL, 32'h48);
    clockMonitorEn <= 1'b1;
    timerOscFailed <= 1'b1;
    chkRd(`SBTC_OFF_CTRL, 32'h8);
    print_verdict;
  end
endmodule // sbtc_timer_bench
`default_nettype wire

// >>> verification/sbtc_timer_props.sv
// Assertions on the APB and interrupt ports of the timer/counter.
`timescale 1ns/1ps
`default_nettype none
module sbtc_timer_props (
  // Clock and reset.
  input wire        core_clk,
  input wire        nrst,
  // APB slave.
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Interrupts.
  input wire        overflowIrq,
  input wire        irq
);
  logic [2:0] busAge_ff;
  // Cycles since the last access phase; a flag may only drop shortly after one.
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst) busAge_ff <= 3'h7;
    else if (psel && penable) busAge_ff <= 3'h0;
    else if (busAge_ff != 3'h7) busAge_ff <= busAge_ff + 3'h1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_ANSWER: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAP: assert property (psel && penable && !pready && paddr > 12'h020 |=> pslverr)
    else $error("unmapped access accepted");
  AST_MAP: assert property (psel && penable && !pready && paddr <= 12'h020 && paddr[1:0] == 2'b00
    |=> !pslverr)
    else $error("mapped access refused");
  AST_ERR_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_HOLD: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("prdata moved outside a read");
  AST_OVF_DROP: assert property ($fell(overflowIrq) |-> busAge_ff < 3'h4)
    else $error("overflow flag cleared by itself");
  AST_IRQ_DROP: assert property ($fell(irq) |-> busAge_ff < 3'h4)
    else $error("irq dropped without access");
endmodule // sbtc_timer_props
bind sbtc_timer sbtc_timer_props u_props (.core_clk(core_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .overflowIrq(overflowIrq), .irq(irq));
`default_nettype wire
